// [verilog/dup_pkg.sv]
// Shared constants and types for the dual serial port pin block
package dup_pkg;
  // Register select codes on reg_select_lines
  localparam logic [3:0] ADR_MODE_A = 4'h0;
  localparam logic [3:0] ADR_STAT_A = 4'h1;
  localparam logic [3:0] ADR_CT_CTRL = 4'h2;
  localparam logic [3:0] ADR_DATA_A = 4'h3;
  localparam logic [3:0] ADR_MODE_B = 4'h4;
  localparam logic [3:0] ADR_STAT_B = 4'h5;
  localparam logic [3:0] ADR_DATA_B = 4'h7;
  localparam logic [3:0] ADR_IMR = 4'h8;
  localparam logic [3:0] ADR_ISR = 4'h9;
  localparam logic [3:0] ADR_OPR = 4'ha;
  localparam logic [3:0] ADR_OUTPUT_CONFIG_REG = 4'hb;
  localparam logic [3:0] ADR_IVR = 4'hc;
  localparam logic [3:0] ADR_IPR = 4'hd;
  localparam logic [3:0] ADR_CT_LOAD = 4'he;
  localparam logic [3:0] ADR_CT_STOP = 4'hf;
  localparam logic [3:0] CH_STRIDE = 4'h4;
  // Reset values
  localparam logic [7:0] IVR_RESET = 8'h0f;
  localparam logic [7:0] REG_CLEAR = 8'h00;
  // Channel mode bits
  localparam int MB_TX_EN = 0;
  localparam int MB_RX_EN = 1;
  localparam int MB_LOOP = 2;
  localparam int MB_TX_EXT = 3;
  localparam int MB_RX_EXT = 4;
  localparam int MB_CTS_EN = 5;
  localparam int MB_RTS_TX = 6;
  localparam int MB_RTS_RX = 7;
  // Output configuration fields
  localparam int OC_OP2_LSB = 0;
  localparam int OC_OP3_LSB = 2;
  localparam int OC_OP4 = 4;
  // Serial framing and rate
  localparam int DATA_BITS = 8;
  localparam logic [3:0] PH_START_MID = 4'h7;
  localparam logic [3:0] PH_BIT_END = 4'hf;
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int OVERSAMPLE = 16;
  localparam int TICK_CYCLES = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
  // State machines
  typedef enum logic {BUS_IDLE, BUS_ACK} dup_bus_st_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} dup_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dup_rx_st_t;
endpackage : dup_pkg

// [verilog/dup_fifo_if.sv]
// Valid/ready carrier between a receiver and its FIFO
`timescale 1ns/1ps
interface dup_fifo_if #(parameter int WIDTH = 8);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic full;
  modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, full);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, full);
endinterface : dup_fifo_if

// [verilog/dup_fifo.sv]
// Small receive FIFO with registered read data
`timescale 1ns/1ps
module dup_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic clk_en, // Freezes state when low
  dup_fifo_if.fifo f // Push and pop sides
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("dup_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [WIDTH-1:0] head;

  // Handshakes and the head slot after this cycle's pop
  wire do_push = f.push_valid && f.push_ready;
  wire do_pop = f.pop_valid && f.pop_ready;
  wire [AW-1:0] next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
  assign f.push_ready = (count != (AW+1)'(DEPTH));
  assign f.full = (count == (AW+1)'(DEPTH));
  assign f.pop_valid = (count != '0);
  assign f.pop_data = head;

  // Storage, no reset needed
  always_ff @(posedge mclk) begin
    if (clk_en && do_push) begin
      mem[wr_ptr] <= f.push_data;
    end
  end

  // Pointers and count; head bypasses a write into the new head slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      head <= '0;
    end else if (clk_en) begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      rd_ptr <= next_rd_ptr;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      head <= (do_push && wr_ptr == next_rd_ptr) ? f.push_data : mem[next_rd_ptr];
    end
  end
endmodule : dup_fifo

// [verilog/dup_top.sv]
// Dual serial channel with asynchronous acknowledged host bus and general pins
`timescale 1ns/1ps
module dup_top import dup_pkg::*; #(
  parameter int BAUD_DIV = TICK_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state when low
  input wire logic chip_sel_low, // Chip select
  input wire logic read_write_sel, // High read, low write
  input wire logic [3:0] reg_select_lines, // Register select
  input wire logic int_ack_low, // Interrupt acknowledge
  input wire logic [7:0] host_data_in, // Data bus level
  output logic [7:0] host_data_out, // Data bus drive value
  output logic host_data_oe_low, // Low while driving the data bus
  output logic transfer_ack_low, // Acknowledge drive value
  output logic transfer_ack_oe_low, // Low while driving acknowledge
  output logic irq_out_low, // Open-drain request value, always 0
  output logic irq_oe_low, // Low while pulling request low
  input wire logic serial_in_a, // Channel A receive line
  input wire logic serial_in_b, // Channel B receive line
  output logic serial_out_a, // Channel A transmit line
  output logic serial_out_b, // Channel B transmit line
  input wire logic [6:0] gp_inputs, // General inputs
  output logic [7:0] gp_outputs, // General output values
  output logic [7:0] gp_oe_low // Low while the pin is driven
);
  if (BAUD_DIV < 2 || FIFO_DEPTH < 2) begin : g_chk
    $error("dup_top: BAUD_DIV and FIFO_DEPTH must be at least 2");
  end

  // Register select for a per-channel offset
  function automatic logic ch_hit(input logic [3:0] adr, input int ch, input logic [3:0] base);
    ch_hit = (adr == base + (ch[0] ? CH_STRIDE : 4'h0));
  endfunction : ch_hit

  // Open-drain drive: value and enable, asserted meaning pulled low
  function automatic logic [1:0] od_drive(input logic assert_low);
    od_drive = {1'b0, !assert_low};
  endfunction : od_drive

  dup_bus_st_t bus_st;
  logic [7:0] int_mask_reg;
  logic [7:0] output_port_reg;
  logic [7:0] output_config_reg;
  logic [7:0] int_vector_reg;
  logic [7:0] ct_load;
  logic ct_ext;
  logic [7:0] ct_cnt;
  logic ct_run;
  logic ct_out;
  logic ct_flag;
  logic ip_delta;
  logic [6:0] ip_prev;
  logic [15:0] div_cnt;
  logic tick;
  logic clk16;
  wire [1:0] txd_w;
  wire [1:0] tx_rdy;
  wire [1:0] rx_rdy;
  wire [1:0] rx_full;
  wire [1:0] ovr;
  wire [1:0] rts_clr;
  wire [1:0] tx1x;
  wire [1:0] rx1x;
  wire [7:0] mode_rd [2];
  wire [7:0] stat_rd [2];
  wire [7:0] rx_rd [2];
  wire [7:0] mode_a;

  // Host strobes, taken once at the start of a cycle
  wire bus_go = (bus_st == BUS_IDLE) && !chip_sel_low;
  wire wr_go = bus_go && !read_write_sel;
  wire rd_go = bus_go && read_write_sel;
  wire [7:0] int_status_reg = {ip_delta, ovr[1], rx_rdy[1], tx_rdy[1], ct_flag, ovr[0], rx_rdy[0], tx_rdy[0]};
  wire irq_pend = |(int_status_reg & int_mask_reg);
  wire iack_go = (bus_st == BUS_IDLE) && chip_sel_low && !int_ack_low && irq_pend;
  wire bus_done = chip_sel_low && int_ack_low;

  // Read data selection
  wire [7:0] read_mux =
    (reg_select_lines == ADR_MODE_A) ? mode_rd[0] :
    (reg_select_lines == ADR_STAT_A) ? stat_rd[0] :
    (reg_select_lines == ADR_DATA_A) ? rx_rd[0] :
    (reg_select_lines == ADR_MODE_B) ? mode_rd[1] :
    (reg_select_lines == ADR_STAT_B) ? stat_rd[1] :
    (reg_select_lines == ADR_DATA_B) ? rx_rd[1] :
    (reg_select_lines == ADR_CT_CTRL) ? {7'h00, ct_ext} :
    (reg_select_lines == ADR_IMR) ? int_mask_reg :
    (reg_select_lines == ADR_ISR) ? int_status_reg :
    (reg_select_lines == ADR_OPR) ? output_port_reg :
    (reg_select_lines == ADR_OUTPUT_CONFIG_REG) ? output_config_reg :
    (reg_select_lines == ADR_IVR) ? int_vector_reg :
    (reg_select_lines == ADR_IPR) ? {1'b0, gp_inputs} :
    (reg_select_lines == ADR_CT_LOAD) ? ct_cnt : 8'h00;

  // Bus cycle: respond, then hold until the host ends the cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_st <= BUS_IDLE;
      host_data_out <= 8'h00;
      host_data_oe_low <= 1'b1;
      transfer_ack_low <= 1'b1;
      transfer_ack_oe_low <= 1'b1;
    end else if (clk_en) begin
      case (bus_st)
        BUS_IDLE: begin
          if (bus_go) begin
            host_data_out <= read_mux;
            host_data_oe_low <= !read_write_sel;
            transfer_ack_low <= 1'b0;
            transfer_ack_oe_low <= 1'b0;
            bus_st <= BUS_ACK;
          end else if (iack_go) begin
            host_data_out <= int_vector_reg;
            host_data_oe_low <= 1'b0;
            transfer_ack_low <= 1'b0;
            transfer_ack_oe_low <= 1'b0;
            bus_st <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          if (bus_done) begin
            host_data_oe_low <= 1'b1;
            transfer_ack_low <= 1'b1;
            transfer_ack_oe_low <= 1'b1;
            bus_st <= BUS_IDLE;
          end
        end
        default: bus_st <= BUS_IDLE;
      endcase
    end
  end

  // Global registers; hardware drop of request-to-send loses to a host write
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_mask_reg <= REG_CLEAR;
      output_port_reg <= REG_CLEAR;
      output_config_reg <= REG_CLEAR;
      int_vector_reg <= IVR_RESET;
      ct_load <= REG_CLEAR;
      ct_ext <= 1'b0;
    end else if (clk_en) begin
      if (wr_go && reg_select_lines == ADR_IMR) int_mask_reg <= host_data_in;
      if (wr_go && reg_select_lines == ADR_OUTPUT_CONFIG_REG) output_config_reg <= host_data_in;
      if (wr_go && reg_select_lines == ADR_IVR) int_vector_reg <= host_data_in;
      if (wr_go && reg_select_lines == ADR_CT_LOAD) ct_load <= host_data_in;
      if (wr_go && reg_select_lines == ADR_CT_CTRL) ct_ext <= host_data_in[0];
      if (wr_go && reg_select_lines == ADR_OPR) begin
        output_port_reg <= host_data_in;
      end else begin
        output_port_reg <= output_port_reg & ~{6'h00, rts_clr};
      end
    end
  end

  // Shared 16x rate tick and its square clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
      clk16 <= 1'b0;
    end else if (clk_en) begin
      tick <= (div_cnt == 16'(BAUD_DIV - 1));
      div_cnt <= (div_cnt == 16'(BAUD_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
      if (tick) clk16 <= !clk16;
    end
  end

  // Counter/timer: down count, square output, sticky event; set wins over stop
  wire ip2_rise = gp_inputs[2] && !ip_prev[2];
  wire ct_step = ct_run && (ct_ext ? ip2_rise : tick);
  wire ct_wrap = ct_step && (ct_cnt == 8'h00);
  always_ff @(posedge mclk) begin
    if (rst) begin
      ct_run <= 1'b0;
      ct_cnt <= 8'h00;
      ct_out <= 1'b1;
      ct_flag <= 1'b0;
    end else if (clk_en) begin
      if (wr_go && reg_select_lines == ADR_CT_LOAD) begin
        ct_run <= 1'b1;
        ct_cnt <= host_data_in;
      end else if (wr_go && reg_select_lines == ADR_CT_STOP) begin
        ct_run <= 1'b0;
      end else if (ct_step) begin
        ct_cnt <= ct_wrap ? ct_load : ct_cnt - 8'h01;
      end
      if (ct_wrap) ct_out <= !ct_out;
      ct_flag <= ct_wrap || (ct_flag && !(wr_go && reg_select_lines == ADR_CT_STOP));
    end
  end

  // Input history and sticky clear-to-send change, set wins over the read
  // History loads the live pins in reset so no false edge follows it
  always_ff @(posedge mclk) begin
    if (rst) begin
      ip_prev <= gp_inputs;
      ip_delta <= 1'b0;
    end else if (clk_en) begin
      ip_prev <= gp_inputs;
      ip_delta <= (gp_inputs[1:0] != ip_prev[1:0]) || (ip_delta && !(rd_go && reg_select_lines == ADR_IPR));
    end
  end

  // Both channels share one description
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic [7:0] mode;
    logic [7:0] thr;
    logic thr_full;
    dup_tx_st_t tst;
    logic [8:0] tsh;
    logic [3:0] tcnt;
    logic tbit;
    logic [3:0] tph;
    logic txd;
    dup_rx_st_t rst_st;
    logic [3:0] rph;
    logic [3:0] rcnt;
    logic [7:0] rsh;
    logic push_v;
    logic ovr_f;
    dup_fifo_if #(.WIDTH(DATA_BITS)) fq ();

    dup_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .clk_en(clk_en),
      .f(fq.fifo)
    );

    // External clock pins: channel A on inputs 3/4, channel B on 5/6
    wire txc_fall = !gp_inputs[3 + 2 * g] && ip_prev[3 + 2 * g];
    wire rxc_rise = gp_inputs[4 + 2 * g] && !ip_prev[4 + 2 * g];
    wire tx_adv = mode[MB_TX_EXT] ? txc_fall : (tick && tph == PH_BIT_END);
    wire cts_ok = !mode[MB_CTS_EN] || !gp_inputs[g];
    wire rx_pin = (g == 0) ? serial_in_a : serial_in_b;
    wire rx_in = mode[MB_LOOP] ? tbit : rx_pin;
    wire samp = mode[MB_RX_EXT] ? rxc_rise : (tick && rph == ((rst_st == RX_START) ? PH_START_MID : PH_BIT_END));
    wire wr_data = wr_go && ch_hit(reg_select_lines, g, ADR_DATA_A);
    wire wr_stat = wr_go && ch_hit(reg_select_lines, g, ADR_STAT_A);

    assign fq.push_valid = push_v;
    assign fq.push_data = rsh;
    assign fq.pop_ready = rd_go && ch_hit(reg_select_lines, g, ADR_DATA_A);
    assign txd_w[g] = txd;
    assign tx_rdy[g] = !thr_full;
    assign rx_rdy[g] = fq.pop_valid;
    assign rx_full[g] = fq.full;
    assign ovr[g] = ovr_f;
    assign rts_clr[g] = mode[MB_RTS_TX] && tst == TX_SHIFT && tx_adv && tcnt == 4'h0 && !thr_full;
    assign tx1x[g] = tph[3];
    assign rx1x[g] = rph[3];
    assign mode_rd[g] = mode;
    assign stat_rd[g] = {3'b000, ovr_f, tst == TX_IDLE && !thr_full, !thr_full, fq.full, fq.pop_valid};
    assign rx_rd[g] = fq.pop_data;

    // Transmitter: start bit, eight data bits, stop bit
    always_ff @(posedge mclk) begin
      if (rst) begin
        mode <= REG_CLEAR;
        thr <= 8'h00;
        thr_full <= 1'b0;
        tst <= TX_IDLE;
        tsh <= 9'h000;
        tcnt <= 4'h0;
        tbit <= 1'b1;
        tph <= 4'h0;
        txd <= 1'b1;
      end else if (clk_en) begin
        if (wr_go && ch_hit(reg_select_lines, g, ADR_MODE_A)) mode <= host_data_in;
        if (tick) tph <= tph + 4'h1;
        if (wr_data && !thr_full && mode[MB_TX_EN]) begin
          thr <= host_data_in;
          thr_full <= 1'b1;
        end
        case (tst)
          TX_IDLE: begin
            tbit <= 1'b1;
            if (tx_adv && thr_full && mode[MB_TX_EN] && cts_ok) begin
              tsh <= {1'b1, thr};
              tcnt <= 4'h9;
              tbit <= 1'b0;
              thr_full <= 1'b0;
              tst <= TX_SHIFT;
            end
          end
          TX_SHIFT: begin
            if (tx_adv) begin
              if (tcnt == 4'h0) begin
                tbit <= 1'b1;
                tst <= TX_IDLE;
              end else begin
                tbit <= tsh[0];
                tsh <= {1'b1, tsh[8:1]};
                tcnt <= tcnt - 4'h1;
              end
            end
          end
          default: tst <= TX_IDLE;
        endcase
        txd <= (mode[MB_LOOP] || !mode[MB_TX_EN] || tst == TX_IDLE) ? 1'b1 : tbit;
      end
    end

    // Receiver: mid-bit sampling on the 16x tick, or external clock rising edges
    always_ff @(posedge mclk) begin
      if (rst) begin
        rst_st <= RX_IDLE;
        rph <= 4'h0;
        rcnt <= 4'h0;
        rsh <= 8'h00;
        push_v <= 1'b0;
        ovr_f <= 1'b0;
      end else if (clk_en) begin
        push_v <= 1'b0;
        if (tick) rph <= rph + 4'h1;
        case (rst_st)
          RX_IDLE: begin
            rcnt <= 4'h0;
            if (mode[MB_RX_EN] && !rx_in) begin
              if (mode[MB_RX_EXT] && rxc_rise) rst_st <= RX_DATA;
              if (!mode[MB_RX_EXT] && tick) begin
                rph <= 4'h0;
                rst_st <= RX_START;
              end
            end
          end
          RX_START: begin
            if (samp) begin
              rph <= 4'h0;
              rst_st <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (samp) begin
              rsh <= {rx_in, rsh[7:1]};
              rcnt <= rcnt + 4'h1;
              if (rcnt == 4'(DATA_BITS - 1)) rst_st <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (samp) begin
              push_v <= 1'b1;
              rst_st <= RX_IDLE;
            end
          end
          default: rst_st <= RX_IDLE;
        endcase
        // Overrun when the FIFO refuses; set wins over the status write
        ovr_f <= (push_v && !fq.push_ready) || (ovr_f && !wr_stat);
      end
    end
  end

  assign mode_a = mode_rd[0];

  // Pin drive, all from flip-flops; open-drain alternates pull low only
  wire [1:0] op0 = {!(output_port_reg[0] && !(mode_a[MB_RTS_RX] && rx_full[0])), 1'b0};
  wire [1:0] op1 = {!(output_port_reg[1] && !(mode_rd[1][MB_RTS_RX] && rx_full[1])), 1'b0};
  wire [1:0] op2_sel = output_config_reg[OC_OP2_LSB +: 2];
  wire [1:0] op3_sel = output_config_reg[OC_OP3_LSB +: 2];
  wire op2_v = (op2_sel == 2'd1) ? clk16 : (op2_sel == 2'd2) ? tx1x[0] : (op2_sel == 2'd3) ? rx1x[0] : !output_port_reg[2];
  wire [1:0] op3 = (op3_sel == 2'd1) ? od_drive(!ct_out) :
    {(op3_sel == 2'd2) ? tx1x[1] : (op3_sel == 2'd3) ? rx1x[1] : !output_port_reg[3], 1'b0};
  wire [1:0] op4 = output_config_reg[OC_OP4] ? od_drive(rx_rdy[0]) : {!output_port_reg[4], 1'b0};
  wire [1:0] op5 = output_config_reg[OC_OP4 + 1] ? od_drive(rx_rdy[1]) : {!output_port_reg[5], 1'b0};
  wire [1:0] op6 = output_config_reg[OC_OP4 + 2] ? od_drive(tx_rdy[0]) : {!output_port_reg[6], 1'b0};
  wire [1:0] op7 = output_config_reg[OC_OP4 + 3] ? od_drive(tx_rdy[1]) : {!output_port_reg[7], 1'b0};

  always_ff @(posedge mclk) begin
    if (rst) begin
      gp_outputs <= 8'hff;
      gp_oe_low <= 8'h00;
      irq_out_low <= 1'b0;
      irq_oe_low <= 1'b1;
      serial_out_a <= 1'b1;
      serial_out_b <= 1'b1;
    end else if (clk_en) begin
      gp_outputs <= {op7[1], op6[1], op5[1], op4[1], op3[1], op2_v, op1[1], op0[1]};
      gp_oe_low <= {op7[0], op6[0], op5[0], op4[0], op3[0], 1'b0, op1[0], op0[0]};
      irq_oe_low <= !irq_pend;
      serial_out_a <= txd_w[0];
      serial_out_b <= txd_w[1];
    end
  end
endmodule : dup_top

// [tb/dup_top_assertions.sv]
// Port checks for the dual serial port block
`timescale 1ns/1ps
module dup_top_chk (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic clk_en, // Run enable
  input wire logic chip_sel_low, // Chip select
  input wire logic read_write_sel, // Read high
  input wire logic int_ack_low, // Vector request
  input wire logic host_data_oe_low, // Bus drive
  input wire logic transfer_ack_low, // Ack value
  input wire logic transfer_ack_oe_low, // Ack drive
  input wire logic irq_out_low, // Request value
  input wire logic irq_oe_low, // Request drive
  input wire logic serial_out_a, // Line A
  input wire logic serial_out_b, // Line B
  input wire logic [7:0] gp_outputs // Output pins
);
  // Request taken only when the previous one has been released
  wire take = clk_en && transfer_ack_oe_low && !chip_sel_low;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_bus_free: assert property ($past(clk_en && chip_sel_low && int_ack_low) |-> host_data_oe_low && transfer_ack_oe_low)
    else $error("bus still driven after release");
  a_ack_answer: assert property (take |=> !transfer_ack_low && !transfer_ack_oe_low)
    else $error("no ack one cycle after request");
  a_read_drive: assert property (take && read_write_sel |=> !host_data_oe_low)
    else $error("read without bus drive");
  a_write_quiet: assert property (take && !read_write_sel |=> host_data_oe_low)
    else $error("bus driven during write");
  a_ack_hold: assert property (clk_en && !transfer_ack_oe_low && !chip_sel_low |=> !transfer_ack_oe_low)
    else $error("ack dropped while selected");
  a_irq_drain: assert property (irq_out_low == 1'b0)
    else $error("request value not low");
  a_vector_reply: assert property (clk_en && chip_sel_low && !int_ack_low && transfer_ack_oe_low && !irq_oe_low
    && $past(!irq_oe_low) |=> !transfer_ack_oe_low && !host_data_oe_low) else $error("no vector reply");
  a_reset_mark: assert property ($past(rst && clk_en) |-> serial_out_a && serial_out_b && gp_outputs == 8'hff)
    else $error("pins wrong after reset");
  // Main scenarios
  c_read: cover property (take && read_write_sel);
  c_irq: cover property (!irq_oe_low);
  c_frame: cover property (!serial_out_a);
endmodule : dup_top_chk
bind dup_top dup_top_chk dup_top_chk_i (.mclk, .rst, .clk_en, .chip_sel_low, .read_write_sel, .int_ack_low,
  .host_data_oe_low, .transfer_ack_low, .transfer_ack_oe_low, .irq_out_low, .irq_oe_low, .serial_out_a,
  .serial_out_b, .gp_outputs);

// [tb/dup_host_model.sv]
// Host partner issuing acknowledged register and vector cycles
`timescale 1ns/1ps
module dup_host_model (
  input wire logic mclk, // Clock
  input wire logic [7:0] host_data_out, // Device drive value
  input wire logic host_data_oe_low, // Device drives bus
  input wire logic transfer_ack_low, // Ack value
  input wire logic transfer_ack_oe_low, // Ack drive
  output logic chip_sel_low, // Chip select
  output logic read_write_sel, // Read high
  output logic [3:0] reg_select_lines, // Register select
  output logic int_ack_low, // Vector request
  output logic [7:0] host_data_in // Bus level
);
  logic wr_drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] pat = 8'h5a;
  initial begin
    chip_sel_low = 1'b1;
    read_write_sel = 1'b1;
    reg_select_lines = 4'h0;
    int_ack_low = 1'b1;
  end
  // Released bus wanders so a stale value never passes
  always @(negedge mclk) pat <= ~pat + 8'h01;
  assign host_data_in = !host_data_oe_low ? host_data_out : (wr_drv ? wd : pat);
  // One cycle; ok stays low if no ack within lim edges
  task automatic cyc(input logic iack, input logic rw, input logic [3:0] a, input logic [7:0] d,
    input int lim, output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(negedge mclk);
    read_write_sel = rw;
    reg_select_lines = a;
    wd = d;
    wr_drv = !rw && !iack;
    chip_sel_low = iack;
    int_ack_low = !iack;
    for (int k = 0; k < lim && !ok; k++) begin
      @(posedge mclk);
      ok = (transfer_ack_oe_low === 1'b0) && (transfer_ack_low === 1'b0);
      q = host_data_in;
    end
    @(negedge mclk);
    chip_sel_low = 1'b1;
    int_ack_low = 1'b1;
    wr_drv = 1'b0;
    @(negedge mclk);
  endtask : cyc
endmodule : dup_host_model

// [tb/dup_top_tb_top.sv]
// Self-checking bench for the dual serial port block
`timescale 1ns/1ps
module dup_top_tb_top;
  import dup_pkg::*;
  localparam int BDIV = 2;
  localparam int BITC = BDIV * OVERSAMPLE;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic [6:0] gp_in = 7'h00;
  logic chip_sel_low, read_write_sel, int_ack_low, host_data_oe_low, transfer_ack_low, transfer_ack_oe_low;
  logic irq_out_low, irq_oe_low, serial_out_a, serial_out_b;
  logic [3:0] reg_select_lines;
  logic [7:0] host_data_in, host_data_out, gp_outputs, gp_oe_low;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] seed = 32'h7d828884;
  // Crossed lines: A transmits into B, B into A
  wire serial_in_a = serial_out_b;
  wire serial_in_b = serial_out_a;
  always #25 mclk = ~mclk;
  // Inputs 0 and 1 start low, granting clear to send
  dup_top #(.BAUD_DIV(BDIV), .FIFO_DEPTH(4)) dup_top_i (.mclk, .rst, .clk_en(run), .chip_sel_low,
    .read_write_sel, .reg_select_lines, .int_ack_low, .host_data_in, .host_data_out, .host_data_oe_low,
    .transfer_ack_low, .transfer_ack_oe_low, .irq_out_low, .irq_oe_low, .serial_in_a, .serial_in_b,
    .serial_out_a, .serial_out_b, .gp_inputs(gp_in), .gp_outputs, .gp_oe_low);
  dup_host_model dup_host_model_i (.mclk, .host_data_out, .host_data_oe_low, .transfer_ack_low,
    .transfer_ack_oe_low, .chip_sel_low, .read_write_sel, .reg_select_lines, .int_ack_low, .host_data_in);
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [7:0] e, input logic [7:0] g, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t %s exp %h got %h", $time, m, e, g);
    end
  endtask : cmp
  task automatic xfer(input logic rw, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    logic ok;
    dup_host_model_i.cyc(1'b0, rw, a, d, 20, q, ok);
    cmp(8'h01, {7'h00, ok}, "bus ack");
  endtask : xfer
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask : wr
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic rnd(output logic [7:0] b);
    seed = nxt(seed);
    b = seed[7:0];
  endtask : rnd
  // Sends one byte on A and checks every bit at mid-bit
  task automatic frame(input logic [7:0] b);
    logic [9:0] f;
    int k;
    f = {1'b1, b, 1'b0};
    wr(ADR_DATA_A, b);
    for (k = 0; k < 4000 && serial_out_a !== 1'b0; k++) @(negedge mclk);
    if (k == 4000) begin
      n_fail++;
      $display("[ERR] %0t no start bit", $time);
      finish_test();
    end
    repeat (BITC / 2) @(negedge mclk);
    for (k = 0; k < 10; k++) begin
      cmp({7'h00, f[k]}, {7'h00, serial_out_a}, "line bit");
      repeat (BITC) @(negedge mclk);
    end
  endtask : frame
  initial begin
    logic [7:0] q, v, b;
    logic ok, lo;
    logic [9:0] f;
    logic [7:0] exp_q[$];
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    cmp(8'hff, gp_outputs, "pins after reset");
    cmp(8'h00, gp_oe_low, "drive after reset");
    cmp(8'h03, {6'h00, serial_out_b, serial_out_a}, "mark after reset");
    xfer(1'b1, ADR_IVR, 8'h00, q);
    cmp(IVR_RESET, q, "vector after reset");
    xfer(1'b1, 4'h6, 8'h00, q);
    cmp(8'h00, q, "unmapped read");
    rnd(v);
    wr(ADR_OPR, v);
    cmp(~v, gp_outputs, "port pins");
    $display("test reset_and_port done");
    // Five frames into a four deep FIFO, first with only the top bit set
    rnd(v);
    wr(ADR_IVR, v);
    wr(ADR_IMR, 8'h20);
    wr(ADR_MODE_B, 8'h02);
    wr(ADR_MODE_A, 8'h01);
    for (int i = 0; i < 5; i++) begin
      rnd(b);
      if (i == 0) b = 8'h80;
      exp_q.push_back(b);
      frame(b);
    end
    xfer(1'b1, ADR_STAT_B, 8'h00, q);
    cmp(8'h13, q & 8'h13, "full and overrun");
    cmp(8'h00, {7'h00, irq_oe_low}, "irq pending");
    dup_host_model_i.cyc(1'b1, 1'b1, 4'h0, 8'h00, 20, q, ok);
    cmp(v, q, "vector reply");
    wr(ADR_OUTPUT_CONFIG_REG, 8'h20);
    cmp(8'h00, {7'h00, gp_oe_low[5]}, "rx ready pin");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ADR_DATA_B, 8'h00, q);
      cmp(exp_q[i], q, "received byte");
    end
    repeat (4) @(negedge mclk);
    cmp(8'h01, {7'h00, irq_oe_low}, "irq cleared");
    cmp(8'h01, {7'h00, gp_oe_low[5]}, "rx ready released");
    dup_host_model_i.cyc(1'b1, 1'b1, 4'h0, 8'h00, 6, q, ok);
    cmp(8'h00, {7'h00, ok}, "iack without pending");
    // Frozen clock enable: no answer, and the write must not land
    run = 1'b0;
    dup_host_model_i.cyc(1'b0, 1'b0, ADR_IVR, 8'h00, 8, q, ok);
    run = 1'b1;
    cmp(8'h00, {7'h00, ok}, "frozen ack");
    xfer(1'b1, ADR_IVR, 8'h00, q);
    cmp(v, q, "frozen write");
    $display("test frames_and_vector done");
    // Loopback keeps the line at mark even with data queued
    wr(ADR_MODE_A, 8'h05);
    wr(ADR_DATA_A, 8'h00);
    lo = 1'b0;
    repeat (12 * BITC) begin
      @(negedge mclk);
      lo = lo | ~serial_out_a;
    end
    cmp(8'h00, {7'h00, lo}, "loopback mark");
    $display("test loopback done");
    // External transmit clock on input 3; first two falls held back by clear to send
    rnd(b);
    f = {1'b1, b, 1'b0};
    gp_in = 7'h01;
    wr(ADR_MODE_A, 8'h29);
    wr(ADR_DATA_A, b);
    for (int k = 0; k < 12; k++) begin
      if (k == 2) gp_in[0] = 1'b0;
      gp_in[3] = 1'b1;
      repeat (4) @(negedge mclk);
      gp_in[3] = 1'b0;
      repeat (4) @(negedge mclk);
      cmp({7'h00, (k < 2) ? 1'b1 : f[k - 2]}, {7'h00, serial_out_a}, "ext clock bit");
    end
    $display("test ext_clock done");
    finish_test();
  end
endmodule : dup_top_tb_top
